// *** logic/pscc_pkg.sv ***
/*
  Shared constants and types for the passive serial configuration receiver.
  Assumes a 10 MHz core clock; the reset timeout is derived from it.
*/
package pscc_pkg;
  // core clock rate and documented times
  localparam int CLK_FREQ_KHZ = 10000;
  localparam int RST_TIMEOUT_US = 100;
  // longest time: rounded down to whole cycles
  localparam int RST_CYCLES = RST_TIMEOUT_US * CLK_FREQ_KHZ / 1000;
  localparam int TMR_W = 10;
  localparam logic [TMR_W-1:0] RST_LAST = TMR_W'(RST_CYCLES - 1);
  localparam int INIT_CYCLES = 299;
  localparam int INIT_W = 9;
  localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_CYCLES - 1);

  // positions of the synchronised pin inputs
  localparam int SY_REQ = 0;
  localparam int SY_STAT = 1;
  localparam int SY_DONE = 2;
  localparam int SY_CE = 3;
  localparam int SY_SCLK = 4;
  localparam int SY_SDAT = 5;
  localparam int SY_UCLK = 6;
  localparam int SY_N = 7;
  // pins idle high after reset so no false edge is seen
  localparam logic [SY_N-1:0] SY_RESET = 7'h7F;

  typedef enum logic [2:0] {
    ST_WAIT = 3'h0,
    ST_LOAD = 3'h1,
    ST_DONE = 3'h2,
    ST_INIT = 3'h3,
    ST_USER = 3'h4,
    ST_ERR = 3'h5,
    ST_REQ = 3'h6
  } pscc_state_t;
endpackage

// *** logic/pscc_frame_if.sv ***
/*
  Carrier between the sequencer and the frame checker.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface pscc_frame_if #(
  parameter int DATA_W = 8
);
  logic clear;
  logic bit_valid;
  logic bit_data;
  logic [DATA_W-1:0] word;
  logic word_valid;
  logic parity_err;

  modport ctrl (
    output clear,
    output bit_valid,
    output bit_data,
    input word,
    input word_valid,
    input parity_err
  );
  modport chk (
    input clear,
    input bit_valid,
    input bit_data,
    output word,
    output word_valid,
    output parity_err
  );
endinterface

// *** logic/pscc_frame_chk.sv ***
/*
  Frame checker: packs DATA_W data bits, msb first, followed by one even parity bit.
  Assumes bit_valid pulses only for accepted bits and clear is held between loads.
*/
`timescale 1ns/1ps
module pscc_frame_chk #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // sequencer side
  pscc_frame_if.chk fr
);
  localparam int CW = $clog2(DATA_W + 1);

  initial begin
    if (DATA_W < 2) begin
      $error("pscc_frame_chk: DATA_W must be at least 2");
    end
  end

  typedef struct packed {
    logic [DATA_W-1:0] sh;
    logic [CW-1:0] cnt;
    logic par;
    logic [DATA_W-1:0] word;
    logic vld;
    logic err;
  } pscc_fc_t;

  pscc_fc_t r_r;
  pscc_fc_t r_nxt;

  always_comb begin
    r_nxt = r_r;
    r_nxt.vld = 1'b0;
    r_nxt.err = 1'b0;
    if (fr.clear) begin
      r_nxt.sh = '0;
      r_nxt.cnt = '0;
      r_nxt.par = 1'b0;
    end else if (fr.bit_valid) begin
      if (r_r.cnt == CW'(DATA_W)) begin
        // parity bit closes the frame; data plus parity must be even
        r_nxt.word = r_r.sh;
        r_nxt.vld = ~(r_r.par ^ fr.bit_data);
        r_nxt.err = r_r.par ^ fr.bit_data;
        r_nxt.cnt = '0;
        r_nxt.par = 1'b0;
      end else begin
        r_nxt.sh = {r_r.sh[DATA_W-2:0], fr.bit_data};
        r_nxt.cnt = CW'(r_r.cnt + 1'b1);
        r_nxt.par = r_r.par ^ fr.bit_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign fr.word = r_r.word;
  assign fr.word_valid = r_r.vld;
  assign fr.parity_err = r_r.err;
endmodule

// *** logic/pscc_top.sv ***
/*
  Passive serial configuration receiver of a programmable target device: takes the
  serial image, drives the open-drain status and load-complete lines, chains the
  next device and times initialization and the error reset.
  Assumes all pins are asynchronous to clk and open-drain wires are resolved outside.
*/
`timescale 1ns/1ps
module pscc_top
  import pscc_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int FRAMES = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // configuration request and options
  input wire logic config_request_n,
  input wire logic auto_restart,
  input wire logic use_user_clock,
  input wire logic user_startup_clock,
  // serial load link
  input wire logic serial_load_clock,
  input wire logic serial_load_data,
  // open-drain status line
  input wire logic status_in,
  output logic status_out,
  output logic status_oe,
  // open-drain load-complete line
  input wire logic load_done_in,
  output logic load_done_out,
  output logic load_done_oe,
  // daisy chain
  input wire logic chain_enable_in_n,
  output logic chain_enable_out_n,
  // user side
  output logic user_mode,
  output logic user_io_enable,
  output logic [DATA_W-1:0] cfg_word,
  output logic cfg_word_valid
);
  import pscc_pkg::*;

  localparam int FW = $clog2(FRAMES);

  initial begin
    if (FRAMES < 2) begin
      $error("pscc_top: FRAMES must be at least 2");
    end
  end

  typedef struct packed {
    pscc_state_t st;
    logic [SY_N-1:0] s1;
    logic [SY_N-1:0] s2;
    logic [SY_N-1:0] s3;
    logic [TMR_W-1:0] tmr;
    logic [INIT_W-1:0] icnt;
    logic [FW-1:0] frm;
    logic ceo_n;
    logic [TMR_W:0] age;
  } pscc_regs_t;

  pscc_regs_t r_r;
  pscc_regs_t r_nxt;
  logic [SY_N-1:0] pins;
  logic req_s;
  logic stat_s;
  logic done_s;
  logic sclk_rise;
  logic init_tick;

  pscc_frame_if #(.DATA_W(DATA_W)) fr ();

  pscc_frame_chk #(.DATA_W(DATA_W)) u_chk (
    .clk(clk),
    .reset_n(reset_n),
    .fr(fr)
  );

  assign pins = {user_startup_clock, serial_load_data, serial_load_clock,
                 chain_enable_in_n, load_done_in, status_in, config_request_n};
  assign req_s = r_r.s2[SY_REQ];
  assign stat_s = r_r.s2[SY_STAT];
  assign done_s = r_r.s2[SY_DONE];
  assign sclk_rise = r_r.s2[SY_SCLK] & ~r_r.s3[SY_SCLK];
  // either the core clock or an edge of the user start-up clock paces init
  assign init_tick = use_user_clock ?
                     (r_r.s2[SY_UCLK] & ~r_r.s3[SY_UCLK]) : 1'b1;

  // only a selected device in the load state takes bits
  assign fr.bit_valid = (r_r.st == ST_LOAD) & sclk_rise & ~r_r.s2[SY_CE]
                        & stat_s & req_s;
  assign fr.bit_data = r_r.s2[SY_SDAT];
  assign fr.clear = (r_r.st != ST_LOAD);

  always_comb begin
    r_nxt = r_r;
    // first stage feeds only the second
    r_nxt.s1 = pins;
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
    if (!req_s) begin
      r_nxt.st = ST_REQ;
    end else begin
      unique case (r_r.st)
        ST_REQ: begin
          r_nxt.st = ST_WAIT;
        end
        ST_WAIT: begin
          r_nxt.frm = '0;
          r_nxt.ceo_n = 1'b1;
          // every device on the shared line must have let go
          if (stat_s) begin
            r_nxt.st = ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (!stat_s) begin
            r_nxt.st = ST_WAIT;
          end else if (fr.parity_err) begin
            r_nxt.st = ST_ERR;
            r_nxt.tmr = '0;
          end else if (fr.word_valid) begin
            r_nxt.frm = FW'(r_r.frm + 1'b1);
            if (r_r.frm == FW'(FRAMES - 1)) begin
              r_nxt.st = ST_DONE;
              r_nxt.ceo_n = 1'b0;
            end
          end
        end
        ST_DONE: begin
          if (!stat_s) begin
            r_nxt.st = ST_WAIT;
          end else if (done_s) begin
            // the tied line rises for every device at once
            r_nxt.st = ST_INIT;
            r_nxt.icnt = '0;
          end
        end
        ST_INIT: begin
          if (!stat_s) begin
            r_nxt.st = ST_WAIT;
          end else if (init_tick) begin
            r_nxt.icnt = INIT_W'(r_r.icnt + 1'b1);
            if (r_r.icnt == INIT_LAST) begin
              r_nxt.st = ST_USER;
            end
          end
        end
        ST_USER: begin
          r_nxt.st = ST_USER;
        end
        ST_ERR: begin
          // without auto restart the line stays low until a request pulse
          if (r_r.tmr != RST_LAST) begin
            r_nxt.tmr = TMR_W'(r_r.tmr + 1'b1);
          end else if (auto_restart) begin
            r_nxt.st = ST_WAIT;
          end
        end
        default: begin
          r_nxt.st = ST_WAIT;
        end
      endcase
    end
    if (r_nxt.st == ST_REQ || r_nxt.st == ST_WAIT || r_nxt.st == ST_ERR) begin
      r_nxt.ceo_n = 1'b1;
    end
    // cycles spent in the error state, read only by the timeout check
    r_nxt.age = (r_r.st == ST_ERR) ? (TMR_W + 1)'(r_r.age + 1'b1) : '0;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r_r.st <= ST_WAIT;
      r_r.s1 <= SY_RESET;
      r_r.s2 <= SY_RESET;
      r_r.s3 <= SY_RESET;
      r_r.tmr <= '0;
      r_r.icnt <= '0;
      r_r.frm <= '0;
      r_r.ceo_n <= 1'b1;
      r_r.age <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // open-drain lines only ever pull low
  assign status_out = 1'b0;
  assign status_oe = (r_r.st == ST_REQ) | (r_r.st == ST_ERR);
  assign load_done_out = 1'b0;
  assign load_done_oe = (r_r.st == ST_REQ) | (r_r.st == ST_WAIT)
                        | (r_r.st == ST_LOAD) | (r_r.st == ST_ERR);
  assign chain_enable_out_n = r_r.ceo_n;
  assign user_mode = (r_r.st == ST_USER);
  assign user_io_enable = (r_r.st == ST_USER);
  assign cfg_word = fr.word;
  assign cfg_word_valid = fr.word_valid;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_last_frame;
    (r_r.st == ST_LOAD) && stat_s && req_s && fr.word_valid && (r_r.frm == FW'(FRAMES - 1));
  endsequence

  a_rise_sample: assert property (
    fr.bit_valid |-> r_r.s2[SY_SCLK] && !r_r.s3[SY_SCLK] && !r_r.s2[SY_CE])
    else $error("bit taken without serial clock rising edge");
  a_done_release: assert property (
    s_last_frame |=> !load_done_oe && !chain_enable_out_n)
    else $error("load-complete not released after last frame");
  a_init_length: assert property (
    $rose(user_mode) && !use_user_clock |-> $past(r_r.st == ST_INIT, 299))
    else $error("user mode entered without 299 init clocks");
  a_err_pulls_status: assert property (
    (r_r.st == ST_LOAD) && stat_s && req_s && fr.parity_err |=> status_oe && !user_mode)
    else $error("status not pulled low on load error");
  // a counter instead of a long delay range, which tools unroll slowly
  a_timeout_release: assert property (
    (r_r.st == ST_ERR) && auto_restart && req_s |-> r_r.age < (TMR_W + 1)'(RST_CYCLES))
    else $error("status not released within reset timeout");
  a_req_drives_low: assert property (
    !req_s |=> status_oe && load_done_oe && !user_io_enable)
    else $error("request low but lines not driven low");
  a_ceo_follows_done: assert property (
    !chain_enable_out_n |-> !load_done_oe && !status_oe)
    else $error("chain enable out low before own load finished");
  a_shared_reset: assert property (
    (r_r.st == ST_LOAD || r_r.st == ST_INIT) && !stat_s && req_s |=> r_r.st == ST_WAIT)
    else $error("shared status low did not reset the load");
  a_tied_start: assert property (
    (r_r.st == ST_DONE) && done_s && stat_s && req_s |=> r_r.st == ST_INIT)
    else $error("init did not start on load-complete rise");
endmodule

// *** testbench/pscc_loader.sv ***
/*
  Loader model: a serial memory that clocks one image into the receiver when selected.
  Assumes the bench resolves the open-drain wires with pull-ups and data is 8 bits.
*/
`timescale 1ns/1ps
module pscc_loader #(
  parameter int FRAMES = 2
) (
  // open-drain wires as seen
  input wire logic status_wire,
  input wire logic done_wire,
  // fault command from the bench
  input wire logic bad_parity,
  // link and output enable; one data line per target, the n = 1 case
  output logic sclk,
  output logic sdat,
  output logic oe_pull
);
  logic [7:0] w;
  bit ok;
  initial begin
    sclk = 1'b0;
    sdat = 1'b1;
    oe_pull = 1'b0;
    forever begin
      wait (status_wire === 1'b1 && done_wire === 1'b0);
      // odd offset keeps link edges off the core clock edges
      #2030;
      ok = 1'b1;
      for (int f = 0; f < FRAMES && ok; f++) begin
        w = 8'h5A ^ 8'(f * 8'h33);
        for (int b = 0; b < 9 && ok; b++) begin
          sdat = (b < 8) ? w[7 - b] : (^w ^ bad_parity);
          #400 sclk = 1'b1;
          #400 sclk = 1'b0;
          ok = status_wire;
        end
      end
      sdat = 1'b1;
      for (int n = 0; n < 64 && ok && done_wire !== 1'b1; n++) #800;
      if (ok && done_wire !== 1'b1) begin
        oe_pull = 1'b1;
        #4000 oe_pull = 1'b0;
      end
    end
  end
endmodule

// *** testbench/pscc_bench.sv ***
/*
  Bench for the configuration receiver: loader model on the link, open-drain
  wires resolved here with pull-ups.
  Assumes the receiver top, its package and the loader model are compiled first.
*/
`timescale 1ns/1ps
module pscc_bench;
  import pscc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic config_request_n = 1'b1;
  logic auto_restart = 1'b1;
  logic chain_enable_in_n = 1'b0;
  logic bad_parity = 1'b0;
  logic use_uclk = 1'b0;
  logic uclk = 1'b0;
  logic sclk, sdat, oe_pull, status_oe, status_out, done_oe, done_out;
  logic ce_out_n, user_mode, io_en, word_valid;
  logic [7:0] word;
  wire status_w = !(status_oe === 1'b1 || oe_pull === 1'b1);
  wire done_w = !(done_oe === 1'b1);
  int err_count = 0;
  int comparisons = 0;
  int nw = 0;

  always #50 clk = ~clk;
  // user start-up clock runs free, also while status is low
  always #400 uclk = ~uclk;

  pscc_top #(.DATA_W(8), .FRAMES(2)) dut_u (
    .clk(clk), .reset_n(reset_n), .config_request_n(config_request_n),
    .auto_restart(auto_restart), .use_user_clock(use_uclk), .user_startup_clock(uclk),
    .serial_load_clock(sclk), .serial_load_data(sdat),
    .status_in(status_w), .status_out(status_out), .status_oe(status_oe),
    .load_done_in(done_w), .load_done_out(done_out), .load_done_oe(done_oe),
    .chain_enable_in_n(chain_enable_in_n), .chain_enable_out_n(ce_out_n),
    .user_mode(user_mode), .user_io_enable(io_en), .cfg_word(word),
    .cfg_word_valid(word_valid));

  pscc_loader #(.FRAMES(2)) loader_u (
    .status_wire(status_w), .done_wire(done_w), .bad_parity(bad_parity),
    .sclk(sclk), .sdat(sdat), .oe_pull(oe_pull));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("comparisons=%0d errors=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    if (word_valid === 1'b1) begin
      check(word, 8'h5A ^ 8'((nw % 2) * 8'h33));
      nw++;
    end
  end

  task automatic pulse_request;
    @(posedge clk);
    config_request_n <= 1'b0;
    // 2 us low plus a margin
    repeat (21) @(posedge clk);
    config_request_n <= 1'b1;
  endtask

  task automatic good_load;
    int i;
    for (i = 0; i < 4000 && ce_out_n !== 1'b0; i++) @(posedge clk);
    #1;
    check(8'(done_oe), 8'h00);
    check(8'(ce_out_n), 8'h00);
    check(8'({status_out, done_out}), 8'h00);
    check(8'(nw), 8'h02);
    repeat (295) @(posedge clk);
    check(8'(user_mode), 8'h00);
    repeat (15) @(posedge clk);
    check(8'(user_mode), 8'h01);
    check(8'(io_en), 8'h01);
  endtask

  task automatic user_reconfig;
    nw = 0;
    @(posedge clk);
    config_request_n <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    check(8'(status_oe), 8'h01);
    check(8'(done_oe), 8'h01);
    check(8'(io_en), 8'h00);
    check(8'(ce_out_n), 8'h01);
    @(posedge clk);
    config_request_n <= 1'b1;
    good_load();
  endtask

  task automatic parity_error(input logic restart);
    int i;
    nw = 0;
    @(posedge clk);
    auto_restart <= restart;
    bad_parity <= 1'b1;
    pulse_request();
    for (i = 0; i < 100 && status_oe !== 1'b0; i++) @(posedge clk);
    for (i = 0; i < 3000 && status_oe !== 1'b1; i++) @(posedge clk);
    #1;
    bad_parity <= 1'b0;
    check(8'(status_oe), 8'h01);
    check(8'(nw), 8'h00);
    repeat (1005) @(posedge clk);
    #1;
    check(8'(status_oe), 8'(!restart));
    if (!restart) begin
      pulse_request();
    end
    good_load();
  endtask

  task automatic ce_blocked;
    int i;
    nw = 0;
    @(posedge clk);
    chain_enable_in_n <= 1'b1;
    pulse_request();
    for (i = 0; i < 4000 && oe_pull !== 1'b1; i++) @(posedge clk);
    #1;
    check(8'(nw), 8'h00);
    check(8'(ce_out_n), 8'h01);
    check(8'(done_oe), 8'h01);
    @(posedge clk);
    chain_enable_in_n <= 1'b0;
    good_load();
  endtask

  task automatic user_clock_init;
    int i;
    nw = 0;
    @(posedge clk);
    use_uclk <= 1'b1;
    pulse_request();
    for (i = 0; i < 4000 && ce_out_n !== 1'b0; i++) @(posedge clk);
    check(8'(nw), 8'h02);
    // fewer than 299 user clock rises cannot finish init
    repeat (290) @(posedge uclk);
    check(8'(user_mode), 8'h00);
    repeat (15) @(posedge uclk);
    check(8'(user_mode), 8'h01);
    @(posedge clk);
    use_uclk <= 1'b0;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    good_load();
    user_reconfig();
    parity_error(1'b1);
    parity_error(1'b0);
    ce_blocked();
    user_clock_init();
    finish_test();
  end

  initial begin
    #5000000;
    err_count++;
    finish_test();
  end
endmodule
